/* rtl/bitop_consts.svh */
// constants for the bit-invert / overflow-branch execute block
// assumes: included by the package and the design files by bare name
`ifndef BITOP_CONSTS_SVH
`define BITOP_CONSTS_SVH

`define INSTR_W     16
`define PC_W        21
`define DADDR_W     12
`define DATA_W      8
`define BANK_W      4
`define OPC_INV     4'h7
`define OPC_BOV     8'hE4
`define FADDR_SPLIT 8'h5F
`define ACC_HI_BANK 4'hF
`define ACC_LO_BANK 4'h0
`define PC_STEP     21'h000002
`define BIT_ONE     8'h01
`define OPC_MSB     15
`define INV_LSB     12
`define BOV_LSB     8
`define BIT_MSB     11
`define BIT_LSB     9
`define ACC_POS     8
`define LIT_MSB     7
`define LIT_LSB     0

`endif

/* rtl/bitop_pkg.sv */
// types shared by the bit-invert / overflow-branch execute block
// assumes: bitop_consts.svh on the include path
`include "bitop_consts.svh"
`default_nettype none

package bitop_pkg;

   typedef enum logic [1:0] {Q1, Q2, Q3, Q4} quarter_t;

   typedef struct packed {
      logic                  valid;
      logic [`INSTR_W-1:0]   word;
   } fetch_t;

   typedef struct packed {
      logic                  rd;
      logic                  wr;
      logic [`DADDR_W-1:0]   addr;
      logic [`DATA_W-1:0]    wdata;
   } mem_req_t;

   typedef struct packed {
      logic                  wr;
      logic [`PC_W-1:0]      value;
   } pc_req_t;

endpackage : bitop_pkg

`default_nettype wire

/* rtl/operand_addr.sv */
// operand address former: access bank, banked or indexed literal offset
// assumes: purely combinational, fed from the latched instruction
`include "bitop_consts.svh"
`default_nettype none

module operand_addr (
   input  wire logic [7:0]           i_faddr,
   input  wire logic                 i_access_sel,
   input  wire logic                 i_ext_en,
   input  wire logic [`BANK_W-1:0]   i_bank_select_register,
   input  wire logic [`DADDR_W-1:0]  i_index_base,
   output logic      [`DADDR_W-1:0]  o_addr
);
   always_comb begin
      if (i_access_sel) begin
         o_addr = {i_bank_select_register, i_faddr};
      end else if (i_ext_en && (i_faddr <= `FADDR_SPLIT)) begin
         // wraps within data space, as the index base does
         o_addr = i_index_base + {4'h0, i_faddr};
      end else if (i_faddr <= `FADDR_SPLIT) begin
         o_addr = {`ACC_LO_BANK, i_faddr};
      end else begin
         o_addr = {`ACC_HI_BANK, i_faddr};
      end
   end
endmodule : operand_addr

`default_nettype wire

/* rtl/bitop_exec.sv */
// execute slice for bit-invert and branch-on-overflow, quarter-phased
// assumes: one enabled clock per quarter, memory read data valid in the
// same quarter as the read strobe stands, fetch word presented during Q1
`include "bitop_consts.svh"
`default_nettype none

module bitop_exec
   import bitop_pkg::*;
(
   input  wire logic                  i_clk,
   input  wire logic                  i_nrst,
   input  wire logic                  i_ce,
   input  wire bitop_pkg::fetch_t     i_fetch,
   input  wire logic                  i_ovf,
   input  wire logic                  i_ext_en,
   input  wire logic [`BANK_W-1:0]    i_bank_select_register,
   input  wire logic [`DADDR_W-1:0]   i_index_base,
   input  wire logic [`PC_W-1:0]      i_pc,
   input  wire logic [`DATA_W-1:0]    i_mem_rdata,
   output bitop_pkg::mem_req_t        o_mem,
   output bitop_pkg::pc_req_t         o_pc,
   output bitop_pkg::quarter_t        o_quarter,
   output logic                       o_nop_cycle,
   output logic                       o_flag_we
);
   import bitop_pkg::*;

   quarter_t            q_q, q_d;
   fetch_t              ir_q, ir_d;
   logic                nop_q, nop_d;
   mem_req_t            mem_q, mem_d;
   pc_req_t             pc_q, pc_d;
   logic                is_inv, is_bov;
   logic [2:0]          bit_sel;
   logic [7:0]          faddr;
   logic [`DATA_W-1:0]  bit_mask;
   logic [`DADDR_W-1:0] op_addr;
   logic [`PC_W-1:0]    br_off;

   assign is_inv   = ir_q.valid && (ir_q.word[`OPC_MSB:`INV_LSB] == `OPC_INV);
   assign is_bov   = ir_q.valid && (ir_q.word[`OPC_MSB:`BOV_LSB] == `OPC_BOV);
   assign bit_sel  = ir_q.word[`BIT_MSB:`BIT_LSB];
   assign faddr    = ir_q.word[`LIT_MSB:`LIT_LSB];
   assign bit_mask = `BIT_ONE << bit_sel;
   // offset doubled: program words are two bytes apart
   assign br_off   = {{(`PC_W-9){faddr[7]}}, faddr, 1'b0};

   operand_addr u_addr (
      .i_faddr                (faddr),
      .i_access_sel           (ir_q.word[`ACC_POS]),
      .i_ext_en               (i_ext_en),
      .i_bank_select_register (i_bank_select_register),
      .i_index_base           (i_index_base),
      .o_addr                 (op_addr)
   );

   always_comb begin
      q_d   = q_q;
      ir_d  = ir_q;
      nop_d = nop_q;
      mem_d = '0;
      pc_d  = '0;
      if (i_ce) begin
         unique case (q_q)
            Q1: begin
               q_d = Q2;
               // a flushed cycle drops whatever was fetched behind the branch
               ir_d.valid = i_fetch.valid && !nop_q;
               ir_d.word  = i_fetch.word;
            end
            Q2: begin
               q_d = Q3;
               if (is_inv) begin
                  mem_d.rd   = 1'b1;
                  mem_d.addr = op_addr;
               end
            end
            Q3: begin
               q_d = Q4;
               if (is_inv) begin
                  mem_d.wr    = 1'b1;
                  mem_d.addr  = op_addr;
                  mem_d.wdata = i_mem_rdata ^ bit_mask;
               end
               if (is_bov && i_ovf) begin
                  pc_d.wr    = 1'b1;
                  pc_d.value = i_pc + `PC_STEP + br_off;
               end
               // overflow clear: pc_d stays idle, no PC write
            end
            Q4: begin
               q_d   = Q1;
               nop_d = pc_q.wr;
            end
         endcase
      end else begin
         mem_d = mem_q;
         pc_d  = pc_q;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q_q   <= Q1;
         ir_q  <= '0;
         nop_q <= 1'b0;
         mem_q <= '0;
         pc_q  <= '0;
      end else begin
         q_q   <= q_d;
         ir_q  <= ir_d;
         nop_q <= nop_d;
         mem_q <= mem_d;
         pc_q  <= pc_d;
      end
   end

   assign o_mem       = mem_q;
   assign o_pc        = pc_q;
   assign o_quarter   = q_q;
   assign o_nop_cycle = nop_q;
   // neither op owns a flag write port; held low for the core's flag mux
   assign o_flag_we   = 1'b0;

   default clocking cb @(posedge i_clk iff i_ce);
   endclocking
   default disable iff (!i_nrst);

   chk_invert_decode: assert property (
      (q_q == Q1 && i_fetch.valid && !nop_q && i_fetch.word[15:12] == `OPC_INV)
      |=> is_inv && bit_sel == $past(i_fetch.word[11:9]))
      else $error("bit-invert word not decoded");

   chk_toggle_data: assert property (
      (q_q == Q3 && is_inv) |=> o_mem.wr
      && o_mem.wdata == ($past(i_mem_rdata) ^ $past(bit_mask)))
      else $error("written byte is not the read byte with one bit flipped");

   chk_flags_held: assert property (
      (is_inv || is_bov) |-> !o_flag_we)
      else $error("status flags written by bit-invert or branch");

   chk_bank_addr: assert property (
      (q_q == Q3 && o_mem.rd && ir_q.word[8])
      |-> o_mem.addr == {$past(i_bank_select_register), faddr})
      else $error("banked operand address wrong");

   chk_indexed_addr: assert property (
      (q_q == Q2 && is_inv && !ir_q.word[8] && i_ext_en && faddr <= `FADDR_SPLIT)
      |=> o_mem.rd && o_mem.addr == $past(i_index_base) + {4'h0, faddr})
      else $error("indexed literal offset address wrong");

   chk_quarter_seq: assert property (
      (q_q == Q2 && is_inv) |=> o_mem.rd && !o_mem.wr ##1 o_mem.wr && !o_mem.rd
      ##1 !o_mem.rd && !o_mem.wr && q_q == Q1)
      else $error("bit-invert quarter sequence broken");

   chk_branch_target: assert property (
      (q_q == Q3 && is_bov && i_ovf)
      |=> o_pc.wr && q_q == Q4 && o_pc.value == $past(i_pc) + `PC_STEP + $past(br_off))
      else $error("branch target wrong");

   chk_bov_decode: assert property (
      (q_q == Q1 && i_fetch.valid && !nop_q && i_fetch.word[15:8] == `OPC_BOV)
      |=> is_bov ##1 !o_mem.rd ##1 !o_mem.wr)
      else $error("overflow branch not decoded or touched memory");

   chk_nop_after: assert property (
      o_pc.wr |=> nop_q ##1 (nop_q && !is_inv && !is_bov) [*3] ##1 !nop_q)
      else $error("taken branch not followed by one empty cycle");

   chk_no_pc_write: assert property (
      (q_q == Q3 && is_bov && !i_ovf) |=> !o_pc.wr [*4])
      else $error("PC written on untaken branch");

   cov_invert: cover property (q_q == Q3 && is_inv ##1 o_mem.wr);
   cov_taken: cover property (o_pc.wr ##1 nop_q);
   cov_not_taken: cover property (q_q == Q3 && is_bov && !i_ovf);
   cov_indexed: cover property (o_mem.rd && i_ext_en && !ir_q.word[8]);

endmodule : bitop_exec

`default_nettype wire

/* sim/mem_model.sv */
// data memory model facing the execute slice
// assumes: read data is wanted while the read strobe stands
`include "bitop_consts.svh"
`default_nettype none

module mem_model
   import bitop_pkg::*;
(
   input  wire logic                i_clk,
   input  wire bitop_pkg::mem_req_t i_mem,
   output logic [`DATA_W-1:0]       o_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [`DATA_W-1:0] mem [0:4095];
   logic [`DATA_W-1:0] junk_q = 8'h5A;

   // idle bus shows a changing pattern, never stale data
   assign o_rdata = i_mem.rd ? mem[i_mem.addr] : junk_q;

   always @(posedge i_clk) begin
      junk_q <= ~junk_q + 8'h35;
      if (i_mem.wr) mem[i_mem.addr] <= i_mem.wdata;
   end
endmodule : mem_model

`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the bit-invert / overflow-branch slice
// assumes: clock enable held high except in the stall test; memory model answers reads at once
`include "bitop_consts.svh"
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bitop_pkg::*;

   logic                 i_clk = 1'b0;
   logic                 i_nrst = 1'b0;
   logic                 i_ce = 1'b1;
   fetch_t               i_fetch = '0;
   logic                 i_ovf = 1'b0;
   logic                 i_ext_en = 1'b0;
   logic [`BANK_W-1:0]   i_bank_select_register = 4'h3;
   logic [`DADDR_W-1:0]  i_index_base = 12'h000;
   logic [`PC_W-1:0]     i_pc = 21'h000100;
   logic [`DATA_W-1:0]   i_mem_rdata;
   mem_req_t             o_mem;
   pc_req_t              o_pc;
   quarter_t             o_quarter;
   logic                 o_nop_cycle;
   logic                 o_flag_we;
   int                   bad_count = 0;
   int                   comparisons = 0;
   int                   rd_at, wr_at, pc_at;
   logic                 flag_bad;
   logic [`PC_W-1:0]     pc_val;

   always #4 i_clk = ~i_clk;

   bitop_exec bitop_exec_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
      .i_fetch(i_fetch), .i_ovf(i_ovf), .i_ext_en(i_ext_en),
      .i_bank_select_register(i_bank_select_register), .i_index_base(i_index_base),
      .i_pc(i_pc), .i_mem_rdata(i_mem_rdata), .o_mem(o_mem), .o_pc(o_pc),
      .o_quarter(o_quarter), .o_nop_cycle(o_nop_cycle), .o_flag_we(o_flag_we));

   mem_model mem_model_inst (.i_clk(i_clk), .i_mem(o_mem), .o_rdata(i_mem_rdata));

   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("ERROR at %0t: %s", $time, msg);
      end
   endtask : check

   // one instruction cycle; waits out any forced no-op first
   task automatic exec(input logic [15:0] word, input logic ovf);
      int k;
      k = 0;
      {rd_at, wr_at, pc_at, flag_bad} = '0;
      while (!(o_quarter === Q1 && o_nop_cycle === 1'b0) && k < 16) begin
         @(posedge i_clk);
         #1;
         k++;
      end
      i_fetch = '{valid: 1'b1, word: word};
      i_ovf = ovf;
      for (k = 1; k <= 4; k++) begin
         @(posedge i_clk);
         #1;
         i_fetch.valid = 1'b0;
         if (o_mem.rd === 1'b1) rd_at = k;
         if (o_mem.wr === 1'b1) wr_at = k;
         if (o_pc.wr === 1'b1) begin
            pc_at = k;
            pc_val = o_pc.value;
         end
         if (o_flag_we !== 1'b0) flag_bad = 1'b1;
      end
   endtask : exec

   task automatic invert(input logic [2:0] b, input logic a, input logic [7:0] f,
                         input logic [11:0] addr);
      logic [7:0] v;
      v = 8'h75 ^ {f[2:0], 5'h00};
      mem_model_inst.mem[addr] = v;
      exec({4'h7, b, a, f}, 1'b1);
      check(mem_model_inst.mem[addr] === (v ^ (8'h01 << b)), "bit invert");
      check(rd_at == 2 && wr_at == 3 && pc_at == 0, "invert timing");
      check(!flag_bad, "invert flags");
   endtask : invert

   task automatic branch(input logic [7:0] n, input logic ovf);
      logic [20:0] exp;
      exp = i_pc + 21'h000002 + {{12{n[7]}}, n, 1'b0};
      exec({8'hE4, n}, ovf);
      check(pc_at == (ovf ? 3 : 0) && wr_at == 0, "pc load");
      if (ovf) check(pc_val === exp, "branch target");
      check(o_nop_cycle === ovf && !flag_bad, "no-op cycle");
   endtask : branch

   // clock enable low while the read strobe stands: everything must freeze
   task automatic stall_invert();
      logic [7:0] v;
      v = 8'h3C;
      mem_model_inst.mem[12'h322] = v;
      i_fetch = '{valid: 1'b1, word: {4'h7, 3'd6, 1'b1, 8'h22}};
      repeat (2) begin
         @(posedge i_clk);
         #1;
         i_fetch.valid = 1'b0;
      end
      i_ce = 1'b0;
      repeat (3) @(posedge i_clk);
      #1;
      check(o_quarter === Q3 && o_mem.rd === 1'b1, "stall lost strobe");
      check(o_mem.addr === 12'h322, "stall address");
      i_ce = 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      check(o_quarter === Q1 && mem_model_inst.mem[12'h322] === 8'h7C, "stall resume");
   endtask : stall_invert

   // a word offered in the forced no-op cycle must be dropped
   task automatic flushed_word();
      int k;
      mem_model_inst.mem[12'h377] = 8'h00;
      branch(8'h10, 1'b1);
      rd_at = 0;
      i_fetch = '{valid: 1'b1, word: {4'h7, 3'd0, 1'b1, 8'h77}};
      for (k = 1; k <= 4; k++) begin
         @(posedge i_clk);
         #1;
         i_fetch.valid = 1'b0;
         if (o_mem.rd === 1'b1 || o_mem.wr === 1'b1) rd_at = k;
      end
      check(rd_at == 0 && o_nop_cycle === 1'b0, "no-op cycle ran a word");
      check(mem_model_inst.mem[12'h377] === 8'h00, "no-op cycle wrote memory");
   endtask : flushed_word

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   initial begin
      #100000;
      bad_count++;
      complete_run();
   end

   initial begin
      repeat (4) @(posedge i_clk);
      #1;
      i_nrst = 1'b1;
      for (int b = 0; b < 8; b++) begin
         invert(b[2:0], 1'b1, 8'hA0 + b[7:0], {4'h3, 8'hA0 + b[7:0]});
      end
      invert(3'd4, 1'b0, 8'h5F, 12'h05F);
      invert(3'd1, 1'b0, 8'h60, 12'hF60);
      i_ext_en = 1'b1;
      i_index_base = 12'hFF0;
      invert(3'd7, 1'b0, 8'h5F, 12'h04F);
      invert(3'd2, 1'b0, 8'h60, 12'hF60);
      invert(3'd0, 1'b1, 8'h10, 12'h310);
      stall_invert();
      branch(8'h80, 1'b1);
      branch(8'h7F, 1'b1);
      branch(8'h05, 1'b0);
      flushed_word();
      invert(3'd5, 1'b1, 8'hFF, 12'h3FF);
      complete_run();
   end
endmodule : tb

`default_nettype wire
